// File: design/hvs_pkg.sv
// shared constants and types of the high-voltage status and interrupt block
package hvs_pkg;
    // clock rate and transfer time
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned XFER_TIME_NS = 10_000;
    // longest time rounds down, never below one cycle
    localparam int unsigned XFER_CYC_RAW = (XFER_TIME_NS / 1000) * (CLK_HZ / 1_000_000);
    localparam int unsigned XFER_CYC = (XFER_CYC_RAW < 1) ? 1 : XFER_CYC_RAW;
    localparam int unsigned CNT_W = 8;
    localparam logic [CNT_W-1:0] XFER_LAST = CNT_W'(XFER_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // status register layout
    localparam int unsigned DATA_W = 8;
    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
    localparam int unsigned STA_SHORT_BIT = 0;
    localparam int unsigned STA_DROP_BIT = 2;

    // configuration register layout
    localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h00;
    localparam int unsigned CFG_LIN_EN_BIT = 0;
    localparam int unsigned CFG_PASSIVE_BIT = 1;
    localparam int unsigned CFG_REARM_BIT = 2;
    localparam int unsigned CFG_DIAG_BIT = 3;
    localparam int unsigned CFG_DROP_EN_BIT = 4;
    // bits that are stored; rearm self-clears, 7..5 reserved
    localparam logic [DATA_W-1:0] CFG_KEEP_MASK = 8'h1B;

    // commands taken by the command port
    typedef enum logic [1:0] {
        HVS_CMD_READ_STATUS = 2'h0,
        HVS_CMD_READ_CONFIG = 2'h1,
        HVS_CMD_WRITE_CONFIG = 2'h2,
        HVS_CMD_NONE = 2'h3
    } hvs_cmd_t;

    // command port request
    typedef struct packed {
        logic valid;
        hvs_cmd_t cmd;
    } hvs_req_t;

    // command port status bits as read by software
    typedef struct packed {
        logic ok;
        logic busy;
    } hvs_cmd_status_t;

    // transfer sequencer states, one-hot
    typedef enum logic [1:0] {
        HVS_ST_IDLE = 2'h1,
        HVS_ST_XFER = 2'h2
    } hvs_state_t;
endpackage

// File: design/hvs_status_irq.sv
// high-voltage status register, short-circuit interrupt and status transfer
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - 8-bit status, reset zero, reached by command
// - short circuit sets bit 0, driver off unless passive
// - bit 0 cleared when status read
// - status read clears pending interrupt
// - drop flag valid only when enabled
// - drop flag one unless supply fell low
// - drop flag cleared by low supply, disable
// - interrupt only when mask bit set
// - event while idle copies status into data port
// - busy held for ten microseconds
// - driver stays off until rearm written
// - config bit 4 enables drop flag
module hvs_status_irq (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire hvs_pkg::hvs_req_t req_i,                    // command port write
    input wire logic [hvs_pkg::DATA_W-1:0] wdata_i,         // data port value for config writes
    input wire logic lin_short_i,                           // filtered short-circuit detector level
    input wire logic supply_low_i,                          // core supply below 2.1 V
    input wire logic irq_enable_mask_i,                     // high-voltage interrupt enable
    output logic [hvs_pkg::DATA_W-1:0] hv_data_port_o,      // data port read value
    output var hvs_pkg::hvs_cmd_status_t hv_command_port_o, // busy and ok bits
    output logic hv_irq_o,                                  // pending high-voltage interrupt
    output logic lin_drv_en_o,                              // LIN driver enable
    output logic [hvs_pkg::DATA_W-1:0] hv_config_o          // stored configuration
);
    // internal state
    logic short_prev_q;                         // detector level one cycle ago
    logic short_flag_q;                         // status bit 0
    logic drop_flag_q;                          // raw supply-drop flag
    logic drv_off_q;                            // driver latched off by a short
    logic drv_en_q;                             // registered LIN driver enable
    logic [hvs_pkg::DATA_W-1:0] cfg_q;          // stored configuration
    logic [hvs_pkg::DATA_W-1:0] data_q;         // data port
    logic irq_q;                                // pending interrupt
    logic ok_q;                                 // last transfer completed
    logic [hvs_pkg::CNT_W-1:0] cnt_q;           // transfer timer
    hvs_pkg::hvs_state_t state_q;               // sequencer state
    hvs_pkg::hvs_state_t state_d;

    // decoded strobes; commands are refused while a transfer runs
    logic idle;
    logic short_evt;
    logic rd_status;
    logic rd_config;
    logic wr_config;
    logic drop_en;
    logic [hvs_pkg::DATA_W-1:0] status_now;
    logic [hvs_pkg::DATA_W-1:0] status_evt;

    assign idle = (state_q == hvs_pkg::HVS_ST_IDLE);
    assign short_evt = lin_short_i & ~short_prev_q;
    assign rd_status = idle & req_i.valid & (req_i.cmd == hvs_pkg::HVS_CMD_READ_STATUS);
    assign rd_config = idle & req_i.valid & (req_i.cmd == hvs_pkg::HVS_CMD_READ_CONFIG);
    assign wr_config = idle & req_i.valid & (req_i.cmd == hvs_pkg::HVS_CMD_WRITE_CONFIG);
    assign drop_en = cfg_q[hvs_pkg::CFG_DROP_EN_BIT];

    // status view: reserved bits forced to zero
    always_comb begin
        status_now = hvs_pkg::STATUS_RESET;
        status_now[hvs_pkg::STA_SHORT_BIT] = short_flag_q;
        status_now[hvs_pkg::STA_DROP_BIT] = drop_flag_q & drop_en;
        // the copy taken on an event already shows the new short bit
        status_evt = status_now;
        status_evt[hvs_pkg::STA_SHORT_BIT] = 1'b1;
    end

    // edge memory for the detector; a held short raises one event only
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            short_prev_q <= 1'b0;
        end else begin
            short_prev_q <= lin_short_i;
        end
    end

    // short-circuit status bit
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            short_flag_q <= 1'b0;
        end else if (short_evt) begin
            // set on short; set beats a same-cycle read
            short_flag_q <= 1'b1;
        end else if (rd_status) begin
            short_flag_q <= 1'b0;
        end
    end

    // driver latch-off; passive protection leaves the driver on
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            drv_off_q <= 1'b0;
        end else if (short_evt && !cfg_q[hvs_pkg::CFG_PASSIVE_BIT]) begin
            drv_off_q <= 1'b1;
        end else if (wr_config && wdata_i[hvs_pkg::CFG_REARM_BIT]) begin
            drv_off_q <= 1'b0;
        end
    end

    // driver enable register; built from the next enable bit and latch so the pin has no gate after the flops
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            drv_en_q <= 1'b0;
        end else if (short_evt && !cfg_q[hvs_pkg::CFG_PASSIVE_BIT]) begin
            drv_en_q <= 1'b0;
        end else if (wr_config) begin
            drv_en_q <= wdata_i[hvs_pkg::CFG_LIN_EN_BIT] & (wdata_i[hvs_pkg::CFG_REARM_BIT] | ~drv_off_q);
        end
    end

    // configuration; the rearm bit is never stored so it reads back zero
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cfg_q <= hvs_pkg::CONFIG_RESET;
        end else if (wr_config) begin
            cfg_q <= wdata_i & hvs_pkg::CFG_KEEP_MASK;
        end
    end

    // supply-drop flag; reset stands for power-on with a good supply
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            drop_flag_q <= 1'b1;
        end else if (supply_low_i) begin
            drop_flag_q <= 1'b0;
        end else if (wr_config && !wdata_i[hvs_pkg::CFG_DROP_EN_BIT]) begin
            drop_flag_q <= 1'b0;
        end else if (wr_config && !drop_en) begin
            drop_flag_q <= 1'b1;
        end
    end

    // pending interrupt; a new event wins over a clearing read
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            irq_q <= 1'b0;
        end else if (short_evt && irq_enable_mask_i) begin
            irq_q <= 1'b1;
        end else if (rd_status) begin
            irq_q <= 1'b0;
        end
    end

    // sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            hvs_pkg::HVS_ST_IDLE: begin
                if (short_evt) begin
                    state_d = hvs_pkg::HVS_ST_XFER;
                end
            end
            hvs_pkg::HVS_ST_XFER: begin
                if (cnt_q == hvs_pkg::XFER_LAST) begin
                    state_d = hvs_pkg::HVS_ST_IDLE;
                end
            end
            default: begin
                state_d = hvs_pkg::HVS_ST_IDLE;
            end
        endcase
    end

    // sequencer state and timer
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_q <= hvs_pkg::HVS_ST_IDLE;
            cnt_q <= hvs_pkg::CNT_ZERO;
        end else begin
            state_q <= state_d;
            if (state_q == hvs_pkg::HVS_ST_XFER && state_d == hvs_pkg::HVS_ST_XFER) begin
                cnt_q <= cnt_q + 8'h01;
            end else begin
                cnt_q <= hvs_pkg::CNT_ZERO;
            end
        end
    end

    // ok bit: cleared when a transfer starts, set when it ends
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ok_q <= 1'b0;
        end else if (idle && short_evt) begin
            ok_q <= 1'b0;
        end else if (state_q == hvs_pkg::HVS_ST_XFER && state_d == hvs_pkg::HVS_ST_IDLE) begin
            ok_q <= 1'b1;
        end
    end

    // data port: event copy first, then register reads
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            data_q <= hvs_pkg::STATUS_RESET;
        end else if (idle && short_evt) begin
            data_q <= status_evt;
        end else if (rd_status) begin
            data_q <= status_now;
        end else if (rd_config) begin
            data_q <= cfg_q;
        end
    end

    // outputs, all from flip-flops
    assign hv_data_port_o = data_q;
    assign hv_command_port_o = '{ok: ok_q, busy: state_q[1]};
    assign hv_irq_o = irq_q;
    assign hv_config_o = cfg_q;
    assign lin_drv_en_o = drv_en_q;
endmodule

`default_nettype wire

// File: test/hvs_status_irq_assertions.sv
// assertion checker for the high-voltage status block
`timescale 1ns/100ps
`default_nettype none
module hvs_status_irq_chk (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire hvs_pkg::hvs_req_t req_i,
    input wire logic [7:0] wdata_i,
    input wire logic lin_short_i,
    input wire logic supply_low_i,
    input wire logic irq_enable_mask_i,
    input wire logic [7:0] hv_data_port_o,
    input wire hvs_pkg::hvs_cmd_status_t hv_command_port_o,
    input wire logic hv_irq_o,
    input wire logic lin_drv_en_o,
    input wire logic [7:0] hv_config_o
);
    wire logic busy = hv_command_port_o.busy; // transfer in progress
    // status read that the port accepts
    wire logic rd = req_i.valid && !busy && req_i.cmd == hvs_pkg::HVS_CMD_READ_STATUS;
    logic [7:0] cnt_q; // busy cycles seen, cleared while idle
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // counting beats a long repetition, which would slow the tools
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !busy) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    sequence s_rise;
        $rose(lin_short_i);
    endsequence
    sequence s_evt;
        s_rise ##0 !busy;
    endsequence
    a_short_sets_flag: assert property (s_evt |=> hv_data_port_o[0] && busy)
        else $error("short event not copied");
    a_irq_when_on: assert property (s_rise ##0 irq_enable_mask_i |=> hv_irq_o)
        else $error("interrupt missing");
    a_irq_no_cause: assert property (!hv_irq_o && !(irq_enable_mask_i && $rose(lin_short_i)) |=> !hv_irq_o)
        else $error("interrupt without cause");
    a_read_clears_irq: assert property (rd && !$rose(lin_short_i) |=> !hv_irq_o)
        else $error("interrupt kept after read");
    a_busy_length: assert property ($fell(busy) |-> cnt_q == hvs_pkg::XFER_CYC)
        else $error("busy length wrong");
    a_busy_cap: assert property (busy |-> cnt_q < hvs_pkg::XFER_CYC)
        else $error("busy too long");
    a_ok_at_end: assert property ($fell(busy) |-> hv_command_port_o.ok)
        else $error("ok not set at end");
    a_ok_low_busy: assert property (busy |-> !hv_command_port_o.ok)
        else $error("ok set during transfer");
    a_driver_off: assert property (s_rise ##0 !hv_config_o[1] |=> !lin_drv_en_o)
        else $error("driver left on");
    a_resvd_zero: assert property (rd |=> hv_data_port_o[7:3] == 5'h00 && !hv_data_port_o[1])
        else $error("reserved bit set");
    a_copy_resvd: assert property (s_evt |=> hv_data_port_o[7:3] == 5'h00 && !hv_data_port_o[1])
        else $error("reserved bit set in event copy");
    a_drop_gated: assert property (rd && !hv_config_o[4] |=> !hv_data_port_o[2])
        else $error("drop flag shown while off");
    a_busy_refuses: assert property (busy && req_i.valid |=> $stable(hv_config_o))
        else $error("command taken while busy");
endmodule
bind hvs_status_irq hvs_status_irq_chk i_chk (.clk_i, .resetn_i, .req_i, .wdata_i, .lin_short_i, .supply_low_i,
    .irq_enable_mask_i, .hv_data_port_o, .hv_command_port_o, .hv_irq_o, .lin_drv_en_o, .hv_config_o);
`default_nettype wire

// File: test/tb_hv_status_interrupt_transfer.sv
// self-checking bench for the high-voltage status block
`timescale 1ns/100ps
`default_nettype none
module tb_hv_status_interrupt_transfer;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    hvs_pkg::hvs_req_t req_i = '{1'b0, hvs_pkg::HVS_CMD_NONE};
    logic [7:0] wdata_i = 8'h00;
    logic lin_short_i = 1'b0;
    logic supply_low_i = 1'b0;
    logic irq_enable_mask_i = 1'b0;
    logic [7:0] hv_data_port_o;
    hvs_pkg::hvs_cmd_status_t hv_command_port_o;
    logic hv_irq_o;
    logic lin_drv_en_o;
    logic [7:0] hv_config_o;
    logic [7:0] q[$]; // expected data port values, oldest first
    logic rd_seen = 1'b0; // a read was taken at the last edge
    logic bz_q = 1'b0; // busy one cycle ago
    int error_cnt = 0;
    int n_tests = 0;
    int n;
    logic [7:0] cfg;
    always #25 clk_i = ~clk_i;
    hvs_status_irq i_dut (.clk_i, .resetn_i, .req_i, .wdata_i, .lin_short_i, .supply_low_i,
        .irq_enable_mask_i, .hv_data_port_o, .hv_command_port_o, .hv_irq_o, .lin_drv_en_o, .hv_config_o);
    task automatic chk(string s, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    // one command; reads note their result first
    task automatic op(hvs_pkg::hvs_cmd_t c, logic [7:0] w, logic [7:0] e);
        if (c != hvs_pkg::HVS_CMD_WRITE_CONFIG) begin
            q.push_back(e);
        end
        @(posedge clk_i);
        req_i <= '{1'b1, c};
        wdata_i <= w;
        @(posedge clk_i);
        req_i <= '{1'b0, hvs_pkg::HVS_CMD_NONE};
    endtask
    // short event with a refused write while busy
    task automatic ev(logic m, logic p);
        q.push_back(8'h05);
        @(posedge clk_i);
        lin_short_i <= 1'b1;
        irq_enable_mask_i <= m;
        @(posedge clk_i);
        #1;
        chk("irq", m, hv_irq_o);
        chk("busy", 8'h01, hv_command_port_o.busy);
        chk("driver", p, lin_drv_en_o);
        op(hvs_pkg::HVS_CMD_WRITE_CONFIG, 8'($urandom), 8'h00);
        #1;
        n = 0;
        while (hv_command_port_o.busy === 1'b1 && n < 400) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("busy cycles", 8'(hvs_pkg::XFER_CYC - 2), 8'(n));
        chk("ok", 8'h01, hv_command_port_o.ok);
        @(posedge clk_i);
        lin_short_i <= 1'b0;
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // watcher: a result shows after a taken read or at the end of a transfer
    always @(posedge clk_i) begin
        rd_seen <= req_i.valid && req_i.cmd != hvs_pkg::HVS_CMD_WRITE_CONFIG && !hv_command_port_o.busy;
    end
    // software meaning comes from bits 0 and 2 only; the whole byte is still compared to catch reserved bits
    always @(negedge clk_i) begin
        if (rd_seen || (bz_q && !hv_command_port_o.busy)) begin
            chk("data port", q.pop_front(), hv_data_port_o);
        end
        bz_q <= hv_command_port_o.busy;
    end
    initial begin
        void'($urandom(90725));
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        #1;
        chk("reset data", 8'h00, hv_data_port_o);
        chk("reset cfg", 8'h00, hv_config_o);
        chk("reset flags", 8'h00, {4'h0, hv_irq_o, hv_command_port_o, lin_drv_en_o});
        op(hvs_pkg::HVS_CMD_WRITE_CONFIG, 8'h11, 8'h00);
        op(hvs_pkg::HVS_CMD_READ_CONFIG, 8'h00, 8'h11);
        op(hvs_pkg::HVS_CMD_READ_STATUS, 8'h00, 8'h04);
        // active and passive protection, mask off and on
        for (int i = 0; i < 4; i++) begin
            cfg = {6'h04, i[0], 1'b1};
            op(hvs_pkg::HVS_CMD_WRITE_CONFIG, cfg, 8'h00);
            #1;
            chk("config", cfg, hv_config_o);
            ev(i[1], i[0]);
            op(hvs_pkg::HVS_CMD_READ_STATUS, 8'h00, 8'h05);
            #1;
            chk("irq cleared", 8'h00, hv_irq_o);
            op(hvs_pkg::HVS_CMD_READ_STATUS, 8'h00, 8'h04);
            op(hvs_pkg::HVS_CMD_READ_CONFIG, 8'h00, cfg);
            op(hvs_pkg::HVS_CMD_WRITE_CONFIG, cfg | 8'h04, 8'h00);
            @(posedge clk_i);
            #1;
            chk("driver rearm", 8'h01, lin_drv_en_o);
            chk("rearm self clear", cfg, hv_config_o);
        end
        op(hvs_pkg::HVS_CMD_WRITE_CONFIG, 8'h01, 8'h00);
        op(hvs_pkg::HVS_CMD_READ_STATUS, 8'h00, 8'h00);
        op(hvs_pkg::HVS_CMD_WRITE_CONFIG, 8'h11, 8'h00);
        op(hvs_pkg::HVS_CMD_READ_STATUS, 8'h00, 8'h04);
        @(posedge clk_i);
        supply_low_i <= 1'b1;
        @(posedge clk_i);
        supply_low_i <= 1'b0;
        op(hvs_pkg::HVS_CMD_READ_STATUS, 8'h00, 8'h00);
        repeat (2) @(posedge clk_i);
        close_out();
    end
    // watchdog well beyond the expected run of about 890 cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        close_out();
    end
endmodule
`default_nettype wire
